//--- design/trf_formatter.sv
// Formats finished temperature conversions into stored result bytes.
`timescale 1ns/1ps
`include "trf_cfg.svh"
module trf_formatter (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    convDone,
    input  wire trf_pkg::trf_chan_e      convChan,
    input  wire logic signed [15:0]      convRaw,
    input  wire logic [7:0]              configReg,
    output trf_pkg::trf_result_s         localResult,
    output trf_pkg::trf_result_s         remoteResult
);
    import trf_pkg::*;

    trf_result_s next_localResult;
    trf_result_s next_remoteResult;
    trf_result_s formatted;

    // Clamps a default-range value to zero through just under 128 degrees.
    function automatic logic signed [15:0] clampStd(input logic signed [15:0] raw);
        logic signed [15:0] v;
        v = raw;
        if (raw < `TRF_STD_MIN) begin
            v = `TRF_STD_MIN;
        end else if (raw > `TRF_STD_MAX) begin
            v = `TRF_STD_MAX;
        end
        return v;
    endfunction

    // Offsets and clamps an extended-range value.
    // The high limit is tested on the raw value first so that a wrapped sum is never used.
    function automatic logic signed [15:0] clampExt(input logic signed [15:0] raw);
        logic signed [15:0] v;
        v = raw + `TRF_OFFSET;
        if (raw > `TRF_EXT_MAX - `TRF_OFFSET) begin
            v = `TRF_EXT_MAX;
        end else if (v < `TRF_STD_MIN) begin
            v = `TRF_STD_MIN;
        end
        return v;
    endfunction

    // Packs a clamped code into the high and low result bytes.
    function automatic trf_result_s packCode(input logic signed [15:0] v);
        trf_result_s res;
        res.high = v[`TRF_CODE_MSB:`TRF_INT_LSB];
        res.low  = {v[`TRF_FRAC_MSB:0], `TRF_PAD};
        return res;
    endfunction

    // Formats a signed value in sixteenths of a degree for the selected range.
    function automatic trf_result_s formatRaw(input logic signed [15:0] raw,
                                              input logic ext);
        trf_result_s res;
        if (ext) begin
            res = packCode(clampExt(raw));
        end else begin
            res = packCode(clampStd(raw));
        end
        return res;
    endfunction

    always_comb begin
        // Range bit is sampled only when a conversion completes.
        formatted         = formatRaw(convRaw, configReg[`TRF_RANGE_BIT]);
        next_localResult  = localResult;
        next_remoteResult = remoteResult;
        if (convDone) begin
            if (convChan == TRF_LOCAL) begin
                next_localResult = formatted;
            end else begin
                next_remoteResult = formatted;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            localResult  <= '{high: `TRF_BYTE_ZERO, low: `TRF_BYTE_ZERO};
            remoteResult <= '{high: `TRF_BYTE_ZERO, low: `TRF_BYTE_ZERO};
        end else begin
            localResult  <= next_localResult;
            remoteResult <= next_remoteResult;
        end
    end

    local_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL
        |=> localResult == $past(formatted))
        else $error("Local result not stored.");

    remote_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE
        |=> remoteResult == $past(formatted))
        else $error("Remote result not stored.");

    hold_result_a: assert property (@(posedge clk) disable iff (!reset_n)
        !convDone
        |=> $stable(localResult) && $stable(remoteResult))
        else $error("Result changed without conversion.");

    local_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE
        |=> $stable(localResult))
        else $error("Local result changed on remote conversion.");

    remote_kept_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL
        |=> $stable(remoteResult))
        else $error("Remote result changed on local conversion.");

    low_pad_a: assert property (@(posedge clk) disable iff (!reset_n)
        localResult.low[`TRF_FRAC_MSB:0] == `TRF_PAD
        && remoteResult.low[`TRF_FRAC_MSB:0] == `TRF_PAD)
        else $error("Low byte padding not zero.");

    std_neg_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        && convRaw < `TRF_STD_MIN
        |=> remoteResult.high == `TRF_BYTE_ZERO && remoteResult.low == `TRF_BYTE_ZERO)
        else $error("Remote negative not clamped to zero.");

    local_neg_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && !configReg[`TRF_RANGE_BIT]
        && convRaw < `TRF_STD_MIN
        |=> localResult.high == `TRF_BYTE_ZERO && localResult.low == `TRF_BYTE_ZERO)
        else $error("Local negative not clamped to zero.");

    std_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        && convRaw > `TRF_STD_MAX
        |=> remoteResult.high == `TRF_STD_HIGH && remoteResult.low == {`TRF_FRAC_FULL, `TRF_PAD})
        else $error("Remote high not clamped to 127.");

    local_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && !configReg[`TRF_RANGE_BIT]
        && convRaw > `TRF_STD_MAX
        |=> localResult.high == `TRF_STD_HIGH && localResult.low == {`TRF_FRAC_FULL, `TRF_PAD})
        else $error("Local high not clamped to 127.");

    std_top_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        && convRaw == `TRF_STD_MAX
        |=> remoteResult.high == `TRF_STD_HIGH && remoteResult.low == {`TRF_FRAC_FULL, `TRF_PAD})
        else $error("Remote top of default range not kept.");

    std_ceiling_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && !configReg[`TRF_RANGE_BIT]
        |=> localResult.high <= `TRF_STD_HIGH)
        else $error("Local default result above 127.");

    remote_ceiling_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        |=> remoteResult.high <= `TRF_STD_HIGH)
        else $error("Remote default result above 127.");

    std_binary_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && !configReg[`TRF_RANGE_BIT]
        && convRaw >= `TRF_STD_MIN && convRaw <= `TRF_STD_MAX
        |=> localResult.high == $past(convRaw[`TRF_CODE_MSB:`TRF_INT_LSB]))
        else $error("Local default range not plain binary.");

    remote_binary_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        && convRaw >= `TRF_STD_MIN && convRaw <= `TRF_STD_MAX
        |=> remoteResult.high == $past(convRaw[`TRF_CODE_MSB:`TRF_INT_LSB]))
        else $error("Remote default range not plain binary.");

    std_frac_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && !configReg[`TRF_RANGE_BIT]
        && convRaw >= `TRF_STD_MIN && convRaw <= `TRF_STD_MAX
        |=> localResult.low == {$past(convRaw[`TRF_FRAC_MSB:0]), `TRF_PAD})
        else $error("Local fraction not left justified.");

    remote_frac_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && !configReg[`TRF_RANGE_BIT]
        && convRaw >= `TRF_STD_MIN && convRaw <= `TRF_STD_MAX
        |=> remoteResult.low == {$past(convRaw[`TRF_FRAC_MSB:0]), `TRF_PAD})
        else $error("Remote fraction not left justified.");

    ext_offset_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && configReg[`TRF_RANGE_BIT]
        && convRaw >= -`TRF_OFFSET && convRaw <= `TRF_EXT_MAX - `TRF_OFFSET
        |=> localResult.high == 8'($past(convRaw[`TRF_CODE_MSB:`TRF_INT_LSB]) + `TRF_EXT_ADD)
        && localResult.low == {$past(convRaw[`TRF_FRAC_MSB:0]), `TRF_PAD})
        else $error("Local extended offset wrong.");

    remote_offset_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && configReg[`TRF_RANGE_BIT]
        && convRaw >= -`TRF_OFFSET && convRaw <= `TRF_EXT_MAX - `TRF_OFFSET
        |=> remoteResult.high == 8'($past(convRaw[`TRF_CODE_MSB:`TRF_INT_LSB]) + `TRF_EXT_ADD)
        && remoteResult.low == {$past(convRaw[`TRF_FRAC_MSB:0]), `TRF_PAD})
        else $error("Remote extended offset wrong.");

    ext_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && configReg[`TRF_RANGE_BIT]
        && convRaw == `TRF_STD_MIN
        |=> localResult.high == `TRF_EXT_ADD && localResult.low == `TRF_BYTE_ZERO)
        else $error("Extended zero degrees not stored as the offset.");

    ext_clamp_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && configReg[`TRF_RANGE_BIT]
        && convRaw > `TRF_EXT_MAX - `TRF_OFFSET
        |=> localResult.high == `TRF_EXT_HIGH && localResult.low == {`TRF_FRAC_FULL, `TRF_PAD})
        else $error("Local extended high clamp wrong.");

    remote_clamp_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && configReg[`TRF_RANGE_BIT]
        && convRaw > `TRF_EXT_MAX - `TRF_OFFSET
        |=> remoteResult.high == `TRF_EXT_HIGH && remoteResult.low == {`TRF_FRAC_FULL, `TRF_PAD})
        else $error("Remote extended high clamp wrong.");

    ext_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_LOCAL && configReg[`TRF_RANGE_BIT]
        && convRaw < -`TRF_OFFSET
        |=> localResult.high == `TRF_BYTE_ZERO && localResult.low == `TRF_BYTE_ZERO)
        else $error("Local extended low clamp wrong.");

    remote_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
        convDone && convChan == TRF_REMOTE && configReg[`TRF_RANGE_BIT]
        && convRaw < -`TRF_OFFSET
        |=> remoteResult.high == `TRF_BYTE_ZERO && remoteResult.low == `TRF_BYTE_ZERO)
        else $error("Remote extended low clamp wrong.");
endmodule

//--- include/trf_cfg.svh
// Constants for the temperature result formatter.
// How it works
// - Results are 12 bits wide, one step being 0.0625 degrees.
// - Default range gives whole degrees as plain unsigned binary.
// - Default range clamps temperatures below zero to 00h.
// - Default range clamps temperatures above 127 degrees to 7Fh.
// - Configuration bit 2 high selects extended range, low selects default.
// - A range change applies from the next conversion; stored results stay.
// - Extended range adds an offset of 64 before storing.
// - Extended range covers minus 64 to 191 degrees as unsigned offset.
// - Each channel stores a high byte of degrees and a low byte fraction.
// - Fraction sits left justified in low byte bits 7..4, bits 3..0 zero.
`ifndef TRF_CFG_SVH
`define TRF_CFG_SVH
`define TRF_RAW_W      16
`define TRF_FRAC_W     4
`define TRF_RANGE_BIT  2
`define TRF_STD_MIN    16'sh0000
`define TRF_STD_MAX    16'sh07ff
`define TRF_OFFSET     16'sh0400
`define TRF_EXT_MAX    16'sh0fff
`define TRF_PAD        4'h0
`define TRF_BYTE_ZERO  8'h00
`define TRF_CODE_MSB   11
`define TRF_INT_LSB    4
`define TRF_FRAC_MSB   3
`define TRF_STD_HIGH   8'h7f
`define TRF_EXT_HIGH   8'hff
`define TRF_EXT_ADD    8'h40
`define TRF_FRAC_FULL  4'hf
`endif

//--- include/trf_pkg.sv
// Types shared by the temperature result formatter.
package trf_pkg;
    typedef enum logic {TRF_LOCAL, TRF_REMOTE} trf_chan_e;
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } trf_result_s;
endpackage

//--- verif/trf_conv_model.sv
// Conversion engine model that hands finished conversions to the formatter.
`timescale 1ns/1ps
module trf_conv_model (
    input  wire logic          clk,
    output trf_pkg::trf_chan_e convChan,
    output logic               convDone,
    output logic signed [15:0] convRaw
);
    import trf_pkg::*;
    initial begin
        convDone = 1'b0;
        convChan = TRF_LOCAL;
        convRaw  = 16'sh0000;
    end
    // Data is only valid with the done pulse, so it is scrambled right after.
    task automatic send(input trf_chan_e ch, input logic signed [15:0] raw);
        @(negedge clk);
        convDone = 1'b1;
        convChan = ch;
        convRaw  = raw;
        @(negedge clk);
        convDone = 1'b0;
        convRaw  = ~raw;
    endtask
endmodule

//--- verif/trf_formatter_tb.sv
// Self-checking bench for the temperature result formatter.
`timescale 1ns/1ps
module trf_formatter_tb;
    import trf_pkg::*;
    logic               clk, reset_n, convDone;
    logic [7:0]         configReg;
    trf_chan_e          convChan;
    logic signed [15:0] convRaw;
    trf_result_s        localResult, remoteResult;
    int                 errors, n_checks, cycles;
    int                 raws[9] = '{-1040, -1024, -16, 0, 400, 2047, 2048, 3071, 3072};
    trf_conv_model i_trf_conv_model (.clk(clk), .convChan(convChan), .convDone(convDone),
        .convRaw(convRaw));
    trf_formatter i_trf_formatter (.clk(clk), .reset_n(reset_n), .convDone(convDone),
        .convChan(convChan), .convRaw(convRaw), .configReg(configReg),
        .localResult(localResult), .remoteResult(remoteResult));
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input trf_result_s exp, input trf_result_s got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic trf_result_s exp_code(input int raw, input logic ext);
        int v;
        v = ext ? raw + 1024 : raw;
        v = (v < 0) ? 0 : (v > (ext ? 4095 : 2047)) ? (ext ? 4095 : 2047) : v;
        return {v[11:4], v[3:0], 4'h0};
    endfunction
    task automatic conv(input trf_chan_e ch, input int raw, input logic ext);
        trf_result_s got;
        configReg[2] = ext;
        i_trf_conv_model.send(ch, 16'(raw));
        got = (ch == TRF_LOCAL) ? localResult : remoteResult;
        check("result", exp_code(raw, ext), got);
    endtask
    // Sweeps the range selected by ext across both clamps, each value on both channels.
    task automatic test_ranges(input logic ext);
        for (int i = 0; i < 18; i++) conv(trf_chan_e'(i[0]), raws[i / 2], ext);
    endtask
    // A range change without a conversion leaves stored results alone.
    task automatic test_switch();
        conv(TRF_LOCAL, 400, 1'b0);
        configReg[2] = 1'b1;
        repeat (3) @(negedge clk);
        check("kept", 16'h1900, localResult);
        conv(TRF_REMOTE, 400, 1'b1);
        check("local", 16'h1900, localResult);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        configReg = 8'h00;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        check("reset", 16'h0000, localResult | remoteResult);
        test_ranges(1'b0);
        test_ranges(1'b1);
        test_switch();
        print_verdict();
    end
endmodule
